// >>> core/mode_pkg.sv
// Constants, types and decode for the operating-mode output policy block
package mode_pkg;
  localparam int NCH    = 4;
  localparam int DUTY_W = 8;
  localparam int AO_W   = 16;
  localparam int ADDR_W = 4;

  // Physical outputs of the I/O modules; duty in percent code, ao in uA
  typedef struct packed {
    logic [NCH-1:0]             dout;
    logic [NCH-1:0][DUTY_W-1:0] time_proportioning_output;
    logic [NCH-1:0]             step_fwd;
    logic [NCH-1:0]             step_rev;
    logic [NCH-1:0][AO_W-1:0]   ao_code;
  } out_set_t;

  // Off: dout low, 0% duty, both drives off, 0.0 mA
  localparam out_set_t OUT_OFF = '0;

  // Functions that each mode enables or permits
  typedef struct packed {
    logic io_scan;
    logic fb_exec;
    logic diag_mon;
    logic module_detect;
    logic analog_input_calibration;
    logic analog_output_calibration;
    logic cfg_download;
    logic fw_download;
    logic force_ind;
  } perm_t;

  typedef enum {ST_PROGRAM, ST_RUN, ST_OFFLINE, ST_COLD} mode_state_t;

  // Mode request and status codes
  localparam logic [1:0] MODE_PROGRAM = 2'h0;
  localparam logic [1:0] MODE_RUN     = 2'h1;
  localparam logic [1:0] MODE_OFFLINE = 2'h2;
  localparam logic [1:0] MODE_COLD    = 2'h3;

  // Physical selector positions
  localparam logic [1:0] SEL_RUN_LOCK  = 2'h0;
  localparam logic [1:0] SEL_RUN_PROG  = 2'h1;
  localparam logic [1:0] SEL_PROG_LOCK = 2'h2;

  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  // CTRL fields: [1:0] mode request (write starts it), [11:8] fw major
  localparam int REQ_LSB = 0;
  localparam int FW_LSB  = 8;
  localparam logic [3:0] FW_RST = 4'h6;
  localparam logic [3:0] FW_V6  = 4'h6;
  // STATUS fields: [1:0] mode, [2] refused (write 1 clears), [16:8] perm
  localparam int ST_MODE_LSB = 0;
  localparam int ST_REF_BIT  = 2;
  localparam int ST_PERM_LSB = 8;

  // Cold start hold time with outputs off
  localparam int COLD_NS  = 1000;
  localparam int CLK_NS   = 10;
  localparam int COLD_CYC = (COLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 8;

  function automatic perm_t perm_of(input mode_state_t s);
    perm_t p;
    p = '0;
    p.diag_mon      = 1'b1;
    p.module_detect = 1'b1;
    case (s)
      ST_RUN:
      begin
        p.io_scan      = 1'b1;
        p.fb_exec      = 1'b1;
        p.cfg_download = 1'b1;
        p.force_ind    = 1'b1;
      end
      ST_PROGRAM:
      begin
        p.io_scan                   = 1'b1;
        p.analog_input_calibration  = 1'b1;
        p.analog_output_calibration = 1'b1;
        p.cfg_download              = 1'b1;
        p.fw_download               = 1'b1;
      end
      ST_OFFLINE:
      begin
        p.io_scan                  = 1'b1;
        p.analog_input_calibration = 1'b1;
        p.force_ind                = 1'b1;
      end
      default:
      begin
        p.io_scan = 1'b0;
      end
    endcase
    return p;
  endfunction : perm_of

  function automatic logic [1:0] code_of(input mode_state_t s);
    case (s)
      ST_RUN:     return MODE_RUN;
      ST_OFFLINE: return MODE_OFFLINE;
      ST_COLD:    return MODE_COLD;
      default:    return MODE_PROGRAM;
    endcase
  endfunction : code_of
endpackage : mode_pkg

// >>> core/mode_output_policy.sv
// Operating-mode policy: mode sequencer, output select and Avalon registers
// Behaviour
// - Offline entered only from run; else refused
// - Offline: scan on, blocks stopped, outputs frozen
// - Firmware 6.0+: offline to run cold-starts
// - Older firmware: offline to run resumes directly
// - Run: scan, execute, outputs follow blocks
// - Run: download, force lamps; no calibration
// - Program: scan, no execution, outputs off
// - Program: calibration, downloads allowed; no force lamps
// - Offline: input calibration, force lamps; no output cal
// - Diagnostics and module detection in every mode
// - Off: low, 0% duty, drives off, 0 mA
// - Frozen: digital and duty keep last values
// - Frozen: step drives both off
// - Frozen: analog keeps last current
// - Locked selector overrides display mode requests
`timescale 1ns/100ps
`default_nettype none
module mode_output_policy
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [1:0]            sel_pos,
  input  wire mode_pkg::out_set_t    fb_result,
  input  wire logic [mode_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output mode_pkg::out_set_t         io_out,
  output mode_pkg::perm_t            perm,
  output logic                       mem_reinit
);
  import mode_pkg::*;

  mode_state_t      state_ff, nxt_state;
  out_set_t         hold_ff, nxt_hold;
  out_set_t         out_ff, nxt_out;
  perm_t            perm_ff, nxt_perm;
  logic [CNT_W-1:0] cold_ff, nxt_cold;
  logic [3:0]       fw_ff, nxt_fw;
  logic             ref_ff, nxt_ref;
  logic             wait_ff, nxt_wait;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic             reinit_ff, nxt_reinit;
  logic             bus_req, wr_ctrl, wr_stat;
  logic [1:0]       req_code;
  logic             req_valid, refuse;

  // One-cycle answer: waitrequest drops the cycle after a request
  assign bus_req   = avs_read | avs_write;
  assign wr_ctrl   = avs_write & ~wait_ff & (avs_address == CTRL_OFS);
  assign wr_stat   = avs_write & ~wait_ff & (avs_address == STAT_OFS);
  assign req_code  = avs_writedata[REQ_LSB +: 2];

  // Display requests count only in the run/program selector position
  assign req_valid = wr_ctrl & (sel_pos == SEL_RUN_PROG);
  assign refuse    = req_valid & (req_code == MODE_OFFLINE)
                   & (state_ff != ST_RUN);

  // Mode sequencer
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cold   = cold_ff;
    nxt_reinit = 1'b0;
    case (state_ff)
      ST_COLD:
      begin
        // Memory reinit pulsed on entry; outputs off until the hold time runs out
        if (cold_ff == CNT_W'(COLD_CYC - 1))
          nxt_state = ST_RUN;
        else
          nxt_cold = cold_ff + CNT_W'(1);
      end
      ST_RUN:
      begin
        if (sel_pos == SEL_PROG_LOCK)
          nxt_state = ST_PROGRAM;
        else if (req_valid && req_code == MODE_PROGRAM)
          nxt_state = ST_PROGRAM;
        else if (req_valid && req_code == MODE_OFFLINE)
          nxt_state = ST_OFFLINE;
      end
      ST_OFFLINE:
      begin
        if (sel_pos == SEL_PROG_LOCK)
          nxt_state = ST_PROGRAM;
        else if (sel_pos == SEL_RUN_LOCK
                 || (req_valid && req_code == MODE_RUN))
        begin
          if (fw_ff >= FW_V6)
          begin
            nxt_state  = ST_COLD;
            nxt_cold   = '0;
            nxt_reinit = 1'b1;
          end
          else
            nxt_state = ST_RUN;
        end
        else if (req_valid && req_code == MODE_PROGRAM)
          nxt_state = ST_PROGRAM;
      end
      ST_PROGRAM:
      begin
        // Leaving program for run always goes through a cold start
        if (sel_pos == SEL_RUN_LOCK
            || (req_valid && req_code == MODE_RUN))
        begin
          nxt_state  = ST_COLD;
          nxt_cold   = '0;
          nxt_reinit = 1'b1;
        end
      end
      default:
      begin
        nxt_state = ST_PROGRAM;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff  <= ST_PROGRAM;
      cold_ff   <= '0;
      reinit_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      state_ff  <= nxt_state;
      cold_ff   <= nxt_cold;
      reinit_ff <= nxt_reinit;
    end
  end

  // Output select and hold register
  always_comb
  begin
    nxt_hold = hold_ff;
    if (state_ff == ST_RUN && nxt_state == ST_OFFLINE)
      nxt_hold = out_ff;
    nxt_perm = perm_of(nxt_state);
    case (nxt_state)
      ST_RUN:
        nxt_out = fb_result;
      ST_OFFLINE:
      begin
        // Frozen values come from the hold, taken as offline begins
        nxt_out = (state_ff == ST_RUN) ? out_ff : hold_ff;
        nxt_out.dout     = nxt_out.dout;
        nxt_out.step_fwd = '0;
        nxt_out.step_rev = '0;
        nxt_out.ao_code  = nxt_out.ao_code;
      end
      default:
        nxt_out = OUT_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold_ff <= OUT_OFF;
      out_ff  <= OUT_OFF;
      perm_ff <= '0;
    end
    else if (clk_en)
    begin
      hold_ff <= nxt_hold;
      out_ff  <= nxt_out;
      perm_ff <= nxt_perm;
    end
  end

  // Register slave; the refused flag set wins over a clear
  always_comb
  begin
    nxt_wait  = ~(bus_req & wait_ff);
    nxt_fw    = wr_ctrl ? avs_writedata[FW_LSB +: 4] : fw_ff;
    nxt_ref   = refuse | (ref_ff & ~(wr_stat & avs_writedata[ST_REF_BIT]));
    nxt_rdata = '0;
    if (avs_read && wait_ff)
    begin
      if (avs_address == CTRL_OFS)
        nxt_rdata[FW_LSB +: 4] = fw_ff;
      else if (avs_address == STAT_OFS)
      begin
        nxt_rdata[ST_MODE_LSB +: 2] = code_of(state_ff);
        nxt_rdata[ST_REF_BIT]       = ref_ff;
        nxt_rdata[ST_PERM_LSB +: $bits(perm_t)] = perm_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_ff  <= 1'b1;
      fw_ff    <= FW_RST;
      ref_ff   <= 1'b0;
      rdata_ff <= '0;
    end
    else if (clk_en)
    begin
      wait_ff  <= nxt_wait;
      fw_ff    <= nxt_fw;
      ref_ff   <= nxt_ref;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign io_out          = out_ff;
  assign perm            = perm_ff;
  assign mem_reinit      = reinit_ff;

  // Checks on the mode policy
  chk_offline_entry: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && nxt_state == ST_OFFLINE && state_ff != ST_OFFLINE
    |-> state_ff == ST_RUN)
    else $error("offline entered from a mode other than run");
  chk_offline_frozen: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_ff == ST_OFFLINE && nxt_state == ST_OFFLINE
    |=> io_out.dout == $past(io_out.dout)
        && io_out.time_proportioning_output
           == $past(io_out.time_proportioning_output)
        && io_out.ao_code == $past(io_out.ao_code)
        && !perm.fb_exec && perm.io_scan)
    else $error("offline outputs moved or blocks ran");
  chk_cold_exit: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_ff == ST_OFFLINE && nxt_state != ST_OFFLINE
    && nxt_state != ST_PROGRAM && fw_ff >= FW_V6
    |=> mem_reinit && io_out == OUT_OFF)
    else $error("new firmware left offline without cold start");
  chk_resume_exit: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && state_ff == ST_OFFLINE && nxt_state != ST_OFFLINE
    && nxt_state != ST_PROGRAM && fw_ff < FW_V6
    |=> !mem_reinit && state_ff == ST_RUN)
    else $error("old firmware did not resume run");
  chk_run_follow: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && nxt_state == ST_RUN |=> io_out == $past(fb_result)
    && perm.fb_exec && !perm.analog_input_calibration
    && !perm.analog_output_calibration)
    else $error("run outputs do not follow blocks");
  chk_prog_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && nxt_state == ST_PROGRAM |=> io_out == OUT_OFF
    && perm.fw_download && !perm.force_ind)
    else $error("program mode outputs not off");
  chk_offline_perm: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_OFFLINE && $stable(state_ff)
    |-> perm.analog_input_calibration && !perm.analog_output_calibration
    && perm.force_ind && perm.diag_mon)
    else $error("offline permissions wrong");
  chk_step_off: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_OFFLINE ##1 state_ff == ST_OFFLINE
    |-> io_out.step_fwd == '0 && io_out.step_rev == '0)
    else $error("step drives on while frozen");
  chk_lock_wins: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && sel_pos == SEL_PROG_LOCK && state_ff != ST_COLD
    |=> state_ff == ST_PROGRAM)
    else $error("locked program position ignored");
  chk_bus_answer: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && bus_req && wait_ff |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  // A refusal must be flagged even when a clear lands in the same cycle
  chk_refuse_sticky: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    clk_en && refuse |=> ref_ff)
    else $error("refused offline request not flagged");
  // A low enable pauses the scan; mode and outputs must not drift
  chk_enable_freeze: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !clk_en |=> $stable(state_ff) && $stable(io_out))
    else $error("state moved while enable was low");

  cov_offline: cover property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_RUN ##1 state_ff == ST_OFFLINE);
  cov_cold: cover property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_OFFLINE ##1 state_ff == ST_COLD);
  cov_refuse: cover property (@(posedge sys_clk) disable iff (sys_rst)
    refuse);
  cov_resume: cover property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_OFFLINE ##1 state_ff == ST_RUN);
  cov_lock: cover property (@(posedge sys_clk) disable iff (sys_rst)
    state_ff == ST_RUN && sel_pos == SEL_PROG_LOCK);
endmodule : mode_output_policy
`default_nettype wire

// >>> sim/io_rack_model.sv
// Behavioural I/O rack model that feeds block results to the policy block
`timescale 1ns/100ps
`default_nettype none
module io_rack_model
  import mode_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  output mode_pkg::out_set_t      fb_result
);
  logic [3:0] cnt_ff;

  // A new result every scan, so a frozen output cannot hide
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      cnt_ff <= 4'h1;
    else
      cnt_ff <= cnt_ff + 4'h1;

  // Every nibble equal: a mixed snapshot is easy to spot
  assign fb_result = {27{cnt_ff}};
endmodule : io_rack_model
`default_nettype wire

// >>> sim/controller_mode_output_policy_bench.sv
// Self-checking bench for the operating-mode output policy block
`timescale 1ns/100ps
`default_nettype none
module controller_mode_output_policy_bench;
  import mode_pkg::*;
  logic              sys_clk, sys_rst, clk_en;
  logic [1:0]        sel_pos;
  out_set_t          fb_result, io_out, snap, pf;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest, mem_reinit;
  logic [31:0]       avs_writedata, avs_readdata, rdata;
  perm_t             perm;
  int                num_errors, n_tests, n_reinit;

  mode_output_policy dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .sel_pos(sel_pos), .fb_result(fb_result),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .io_out(io_out), .perm(perm), .mem_reinit(mem_reinit));
  io_rack_model rack (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .fb_result(fb_result));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Count restart pulses for the cold-start checks
  always @(posedge sys_clk)
    if (mem_reinit === 1'b1)
      n_reinit++;

  task end_sim;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  // One Avalon transfer; held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    i = 0;
    do
    begin
      @(posedge sys_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 50);
    if (i >= 50)
    begin
      chk(1'b0, "bus hang");
      end_sim();
    end
    // Data taken at the edge where waitrequest is seen low, then release
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    do
    begin
      bus(1'b0, STAT_OFS, 32'h0);
      i++;
    end while (rdata[1:0] !== m && i < 300);
    if (i >= 300)
    begin
      chk(1'b0, "mode never reached");
      end_sim();
    end
  endtask : wait_mode

  // Restart pulse, outputs held off, then back in run
  task watch_cold;
    int i, k;
    logic off;
    k = n_reinit;
    i = 0;
    while (n_reinit == k && i < 20)
    begin
      @(negedge sys_clk);
      i++;
    end
    chk(n_reinit == k + 1, "no restart pulse");
    off = 1'b1;
    repeat (95)
    begin
      @(negedge sys_clk);
      off &= (io_out === OUT_OFF);
    end
    chk(off, "outputs live during restart");
    wait_mode(MODE_RUN);
  endtask : watch_cold

  task t_reset;
    repeat (3) @(negedge sys_clk);
    chk(perm === 9'h17e, "program permissions");
    chk(perm.diag_mon & perm.module_detect, "diagnostics");
    chk(io_out === OUT_OFF, "outputs not off");
    bus(1'b0, 4'h8, 32'h0);
    chk(rdata === 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task t_refuse;
    bus(1'b1, CTRL_OFS, 32'h0602);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rdata[2:0] === 3'h4, "offline from program taken");
    bus(1'b1, STAT_OFS, 32'h4);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rdata[2] === 1'b0, "refused flag stuck");
    $display("test refuse done");
  endtask : t_refuse

  task t_run;
    bus(1'b1, CTRL_OFS, 32'h0601);
    watch_cold();
    chk(rdata[16:8] === 9'h1e5, "run permissions");
    @(negedge sys_clk);
    pf = fb_result;
    repeat (5)
    begin
      @(negedge sys_clk);
      chk(io_out === pf, "outputs not from blocks");
      pf = fb_result;
    end
    // Enable low must freeze outputs although block results move on
    @(posedge sys_clk);
    clk_en <= 1'b0;
    @(negedge sys_clk);
    pf = io_out;
    repeat (5)
    begin
      @(negedge sys_clk);
      chk(io_out === pf, "outputs moved with enable low");
    end
    @(posedge sys_clk);
    clk_en <= 1'b1;
    $display("test run done");
  endtask : t_run

  task t_offline;
    logic s;
    bus(1'b1, CTRL_OFS, 32'h0602);
    wait_mode(MODE_OFFLINE);
    chk(perm === 9'h171, "offline permissions");
    @(negedge sys_clk);
    snap = io_out;
    chk((snap.step_fwd | snap.step_rev) === 4'h0, "drives on");
    chk(snap.ao_code === {16{snap.dout}}, "mixed hold");
    s = 1'b1;
    repeat (20)
    begin
      @(negedge sys_clk);
      s &= (io_out === snap);
    end
    chk(s, "outputs not frozen");
    $display("test offline done");
  endtask : t_offline

  task t_resume;
    int k;
    bus(1'b1, CTRL_OFS, 32'h0601);
    watch_cold();
    bus(1'b1, CTRL_OFS, 32'h0502);
    wait_mode(MODE_OFFLINE);
    k = n_reinit;
    bus(1'b1, CTRL_OFS, 32'h0501);
    wait_mode(MODE_RUN);
    chk(n_reinit == k, "restart on old firmware");
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rdata[11:8] === 4'h5, "firmware readback");
    $display("test resume done");
  endtask : t_resume

  task t_lock;
    sel_pos <= SEL_RUN_LOCK;
    bus(1'b1, CTRL_OFS, 32'h0500);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rdata[1:0] === MODE_RUN, "request in run lock");
    sel_pos <= SEL_PROG_LOCK;
    wait_mode(MODE_PROGRAM);
    chk(io_out === OUT_OFF, "program outputs");
    chk(perm === 9'h17e, "program permissions");
    bus(1'b1, CTRL_OFS, 32'h0501);
    repeat (3) @(posedge sys_clk);
    bus(1'b0, STAT_OFS, 32'h0);
    chk(rdata[1:0] === MODE_PROGRAM, "request in prog lock");
    $display("test lock done");
  endtask : t_lock

  // Main sequence
  initial
  begin
    sys_rst       = 1'b1;
    clk_en        = 1'b1;
    sel_pos       = SEL_RUN_PROG;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_refuse();
    t_run();
    t_offline();
    t_resume();
    t_lock();
    end_sim();
  end
endmodule : controller_mode_output_policy_bench
`default_nettype wire
